/* hdl/aacb_exec.sv */
// Function
// - add literal into accumulator
// - add accumulator and file register
// - add accumulator, file register, carry
// - carry add updates all five flags
// - d bit picks accumulator or file
// - a bit picks access bank or bank
// - AND literal into accumulator
// - AND accumulator with file register
// - AND updates only sign and zero
// - branch only when carry set
// - taken target is pc plus 2 plus 2n
// - taken branch adds idle cycle
// - four phases decode read process write
`timescale 1ns/100ps
module aacb_exec (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output aacb_pkg::aacb_phase_e exec_phase
);
  import aacb_pkg::*;

  aacb_phase_e  phase_q;
  aacb_decode_s dec_q;
  aacb_status_s status_q;
  aacb_status_s status_new_q;
  aacb_status_s alu_status;
  logic [15:0]  opcode_q;
  logic [7:0]   accum_q;
  logic [3:0]   bank_q;
  logic [20:0]  pc_q;
  logic [11:0]  mem_addr_q;
  logic [11:0]  daddr_q;
  logic [7:0]   operand_q;
  logic [7:0]   result_q;
  logic [7:0]   alu_result;
  logic         take_q;
  logic         nop_cycle_q;
  logic         unsupported_q;
  logic         rd_ready_q;
  logic [31:0]  rd_mux;
  logic [7:0]   mem [MEM_DEPTH];
  logic         busy;
  logic         wr_acc;
  logic         rd_acc;
  logic         start;
  logic         again;
  logic         live;
  logic         ph4_write;
  logic [31:0]  wd_acc;
  logic [31:0]  wd_pc;
  logic [31:0]  wd_op;
  logic [31:0]  wd_ma;

  // Bus handshake: reads take one wait state, all wait while busy
  assign busy            = (phase_q != PHASE_IDLE);
  assign wr_acc          = avs_write && !busy;
  assign rd_acc          = avs_read && !busy && rd_ready_q;
  assign avs_waitrequest = (busy && (avs_read || avs_write)) ||
                           (avs_read && !rd_ready_q);
  assign start           = wr_acc && (avs_address == OFS_INSTR);
  assign live            = !nop_cycle_q;
  assign ph4_write       = (phase_q == PHASE_FOUR) && live;
  assign exec_phase      = phase_q;
  assign wd_acc = be_merge({24'h000000, accum_q}, avs_writedata,
                           avs_byteenable);
  assign wd_pc  = be_merge({11'h000, pc_q}, avs_writedata, avs_byteenable);
  assign wd_op  = be_merge({16'h0000, opcode_q}, avs_writedata,
                           avs_byteenable);
  assign wd_ma  = be_merge({20'h00000, mem_addr_q}, avs_writedata,
                           avs_byteenable);

  assign again = ph4_write && take_q;

  aacb_phase_seq u_seq (
    .clk     (clk),
    .reset   (reset),
    .start   (start),
    .again   (again),
    .phase_q (phase_q)
  );

  aacb_alu u_alu (
    .op         (dec_q.op),
    .accum      (accum_q),
    .operand    (operand_q),
    .status_in  (status_q),
    .result     (alu_result),
    .status_out (alu_status)
  );

  // Register read decode
  always_comb begin
    if (avs_address == OFS_INSTR) begin
      rd_mux = {16'h0000, opcode_q};
    end else if (avs_address == OFS_ACCUM) begin
      rd_mux = {24'h000000, accum_q};
    end else if (avs_address == OFS_STATUS) begin
      rd_mux = {27'h0000000, status_q};
    end else if (avs_address == OFS_BANK) begin
      rd_mux = {28'h0000000, bank_q};
    end else if (avs_address == OFS_PC) begin
      rd_mux = {11'h000, pc_q};
    end else if (avs_address == OFS_MEM_ADDR) begin
      rd_mux = {20'h00000, mem_addr_q};
    end else if (avs_address == OFS_MEM_DATA) begin
      rd_mux = {24'h000000, mem[mem_addr_q]};
    end else if (avs_address == OFS_EXEC_STAT) begin
      rd_mux = {25'h0000000, unsupported_q, nop_cycle_q, phase_q};
    end else begin
      rd_mux = 32'h00000000;
    end
  end

  // Read data capture, answered on the following cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_ready_q   <= 1'b0;
      avs_readdata <= 32'h00000000;
    end else if (rd_acc) begin
      rd_ready_q   <= 1'b0;
    end else if (avs_read && !busy) begin
      rd_ready_q   <= 1'b1;
      avs_readdata <= rd_mux;
    end
  end

  // Opcode register and bank, memory window address
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      opcode_q   <= RST_OPCODE;
      bank_q     <= RST_BANK;
      mem_addr_q <= RST_MEM_ADDR;
    end else if (wr_acc) begin
      if (avs_address == OFS_INSTR) begin
        opcode_q <= wd_op[15:0];
      end else if (avs_address == OFS_BANK && avs_byteenable[0]) begin
        bank_q <= avs_writedata[3:0];
      end else if (avs_address == OFS_MEM_ADDR) begin
        mem_addr_q <= wd_ma[11:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dec_q <= '0;
    end else if (phase_q == PHASE_ONE && live) begin
      dec_q <= decode_opcode(opcode_q);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      daddr_q       <= 12'h000;
      operand_q     <= 8'h00;
      unsupported_q <= 1'b0;
    end else if (phase_q == PHASE_TWO && live) begin
      unsupported_q <= (dec_q.op == OP_NONE);
      if (dec_q.bank_sel) begin
        daddr_q <= {bank_q, dec_q.field};
      end else if (dec_q.field < ACCESS_SPLIT) begin
        daddr_q <= {ACCESS_LO_BANK, dec_q.field};
      end else begin
        daddr_q <= {ACCESS_HI_BANK, dec_q.field};
      end
      if (!is_file_op(dec_q.op)) begin
        operand_q <= dec_q.field;
      end else if (dec_q.bank_sel) begin
        operand_q <= mem[{bank_q, dec_q.field}];
      end else if (dec_q.field < ACCESS_SPLIT) begin
        operand_q <= mem[{ACCESS_LO_BANK, dec_q.field}];
      end else begin
        operand_q <= mem[{ACCESS_HI_BANK, dec_q.field}];
      end
    end
  end

  // process phase, branch decision on carry
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      result_q     <= 8'h00;
      status_new_q <= RST_STATUS;
      take_q       <= 1'b0;
    end else if (phase_q == PHASE_THREE && live) begin
      result_q     <= alu_result;
      status_new_q <= alu_status;
      take_q       <= (dec_q.op == OP_BRANCH_ON_CARRY) && status_q.carry;
    end
  end

  // Idle cycle flag after a taken branch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      nop_cycle_q <= 1'b0;
    end else if (phase_q == PHASE_FOUR) begin
      nop_cycle_q <= again;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      accum_q <= RST_ACCUM;
    end else if (wr_acc && avs_address == OFS_ACCUM) begin
      accum_q <= wd_acc[7:0];
    end else if (ph4_write) begin
      if (dec_q.op == OP_ADD_LITERAL_ACCUM ||
          dec_q.op == OP_AND_LITERAL_ACCUM ||
          (is_file_op(dec_q.op) && !dec_q.dest_file)) begin
        accum_q <= result_q;
      end
    end
  end

  // flags written from the alu, which keeps untouched bits
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      status_q <= RST_STATUS;
    end else if (wr_acc && avs_address == OFS_STATUS &&
                 avs_byteenable[0]) begin
      status_q <= avs_writedata[4:0];
    end else if (ph4_write) begin
      status_q <= status_new_q;
    end
  end

  // program counter step and relative branch
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pc_q <= RST_PC;
    end else if (wr_acc && avs_address == OFS_PC) begin
      pc_q <= {wd_pc[20:1], 1'b0};
    end else if (phase_q == PHASE_ONE && live) begin
      pc_q <= pc_q + PC_STEP;
    end else if (ph4_write && take_q) begin
      pc_q <= pc_q + {{12{dec_q.field[7]}}, dec_q.field, 1'b0};
    end
  end

  // file destination write, bus writes only when idle
  always_ff @(posedge clk) begin
    if (wr_acc && avs_address == OFS_MEM_DATA && avs_byteenable[0]) begin
      mem[mem_addr_q] <= avs_writedata[7:0];
    end else if (ph4_write && is_file_op(dec_q.op) && dec_q.dest_file) begin
      mem[daddr_q] <= result_q;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  logic [7:0] chk_sum;
  logic [8:0] chk_addc;
  assign chk_sum  = accum_q + operand_q;
  assign chk_addc = {1'b0, accum_q} + {1'b0, operand_q} +
                    {8'h00, status_q.carry};
  property p_add_lit;
    ph4_write && dec_q.op == OP_ADD_LITERAL_ACCUM
    |=> accum_q == $past(chk_sum);
  endproperty
  a_add_lit: assert property (p_add_lit)
    else $error("literal add wrong");
  property p_add_file;
    ph4_write && dec_q.op == OP_ADD_ACCUM_TO_FILE && dec_q.dest_file
    |=> mem[$past(daddr_q)] == $past(chk_sum) && $stable(accum_q);
  endproperty
  a_add_file: assert property (p_add_file)
    else $error("file add wrong");
  property p_addc;
    ph4_write && dec_q.op == OP_ADD_ACCUM_FILE_CARRY && !dec_q.dest_file
    |=> accum_q == $past(chk_addc[7:0]);
  endproperty
  a_addc: assert property (p_addc)
    else $error("carry add wrong");
  property p_addc_flags;
    ph4_write && dec_q.op == OP_ADD_ACCUM_FILE_CARRY
    |=> status_q.carry == $past(chk_addc[8]) &&
        status_q.zero == ($past(chk_addc[7:0]) == 8'h00) &&
        status_q.negative == $past(chk_addc[7]);
  endproperty
  a_addc_flags: assert property (p_addc_flags)
    else $error("carry add flags wrong");
  property p_bank_sel;
    phase_q == PHASE_TWO && live && dec_q.bank_sel
    |=> daddr_q == {$past(bank_q), $past(dec_q.field)};
  endproperty
  a_bank_sel: assert property (p_bank_sel)
    else $error("banked address wrong");
  property p_and_flags;
    ph4_write && (dec_q.op == OP_AND_LITERAL_ACCUM ||
                  dec_q.op == OP_AND_ACCUM_FILE)
    |=> $stable(status_q.carry) && $stable(status_q.low_nibble_out) &&
        $stable(status_q.twos_comp_error_bit);
  endproperty
  a_and_flags: assert property (p_and_flags)
    else $error("and touched arithmetic flags");
  property p_and_lit;
    ph4_write && dec_q.op == OP_AND_LITERAL_ACCUM
    |=> accum_q == ($past(accum_q) & $past(operand_q));
  endproperty
  a_and_lit: assert property (p_and_lit)
    else $error("literal and wrong");
  property p_no_jump;
    ph4_write && dec_q.op == OP_BRANCH_ON_CARRY && !status_q.carry
    |=> $stable(pc_q) && phase_q == PHASE_IDLE;
  endproperty
  a_no_jump: assert property (p_no_jump)
    else $error("branch taken without carry");
  property p_jump_target;
    ph4_write && take_q
    |=> pc_q == $past(pc_q) + {{12{$past(dec_q.field[7])}},
                               $past(dec_q.field), 1'b0};
  endproperty
  a_jump_target: assert property (p_jump_target)
    else $error("branch target wrong");
  // The target lands on the first idle phase, then nothing moves
  sequence s_idle_cycle;
    nop_cycle_q ##1 (nop_cycle_q && $stable(pc_q) && $stable(accum_q))[*3]
    ##1 phase_q == PHASE_IDLE;
  endsequence
  property p_jump_two_cycles;
    ph4_write && take_q |=> s_idle_cycle;
  endproperty
  a_jump_two_cycles: assert property (p_jump_two_cycles)
    else $error("taken branch cycle wrong");

endmodule : aacb_exec

/* common/aacb_pkg.sv */
package aacb_pkg;

  // Register byte offsets on the slave port
  localparam logic [4:0]  OFS_INSTR     = 5'h00;
  localparam logic [4:0]  OFS_ACCUM     = 5'h04;
  localparam logic [4:0]  OFS_STATUS    = 5'h08;
  localparam logic [4:0]  OFS_BANK      = 5'h0c;
  localparam logic [4:0]  OFS_PC        = 5'h10;
  localparam logic [4:0]  OFS_MEM_ADDR  = 5'h14;
  localparam logic [4:0]  OFS_MEM_DATA  = 5'h18;
  localparam logic [4:0]  OFS_EXEC_STAT = 5'h1c;

  // Values after reset
  localparam logic [15:0] RST_OPCODE    = 16'h0000;
  localparam logic [7:0]  RST_ACCUM     = 8'h00;
  localparam logic [4:0]  RST_STATUS    = 5'h00;
  localparam logic [3:0]  RST_BANK      = 4'h0;
  localparam logic [20:0] RST_PC        = 21'h000000;
  localparam logic [11:0] RST_MEM_ADDR  = 12'h000;

  // Data memory and access bank layout
  localparam int unsigned MEM_DEPTH      = 4096;
  localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
  localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
  localparam logic [20:0] PC_STEP        = 21'h000002;

  // Opcode patterns and field positions
  localparam logic [7:0]  OPC_ADD_LIT_HI   = 8'h0f;
  localparam logic [7:0]  OPC_AND_LIT_HI   = 8'h0b;
  localparam logic [7:0]  OPC_BRANCH_C_HI  = 8'he2;
  localparam logic [5:0]  OPC_ADD_FILE_HI  = 6'h09;
  localparam logic [5:0]  OPC_ADDC_FILE_HI = 6'h08;
  localparam logic [5:0]  OPC_AND_FILE_HI  = 6'h05;
  localparam int unsigned OPC_D_BIT        = 9;
  localparam int unsigned OPC_A_BIT        = 8;

  // Phases of one instruction cycle
  typedef enum logic [4:0] {
    PHASE_IDLE  = 5'b00001,
    PHASE_ONE   = 5'b00010,
    PHASE_TWO   = 5'b00100,
    PHASE_THREE = 5'b01000,
    PHASE_FOUR  = 5'b10000
  } aacb_phase_e;

  typedef enum logic [2:0] {
    OP_NONE                 = 3'h0,
    OP_ADD_LITERAL_ACCUM    = 3'h1,
    OP_ADD_ACCUM_TO_FILE    = 3'h2,
    OP_ADD_ACCUM_FILE_CARRY = 3'h3,
    OP_AND_LITERAL_ACCUM    = 3'h4,
    OP_AND_ACCUM_FILE       = 3'h5,
    OP_BRANCH_ON_CARRY      = 3'h6
  } aacb_op_e;

  typedef struct packed {
    logic negative;
    logic twos_comp_error_bit;
    logic zero;
    logic low_nibble_out;
    logic carry;
  } aacb_status_s;

  typedef struct packed {
    aacb_op_e   op;
    logic       dest_file;
    logic       bank_sel;
    logic [7:0] field;
  } aacb_decode_s;

  // Split an opcode into operation, destination, bank bit and field
  function automatic aacb_decode_s decode_opcode(input logic [15:0] opc);
    aacb_decode_s d;
    d.op        = OP_NONE;
    d.dest_file = opc[OPC_D_BIT];
    d.bank_sel  = opc[OPC_A_BIT];
    d.field     = opc[7:0];
    if (opc[15:8] == OPC_ADD_LIT_HI) begin
      d.op = OP_ADD_LITERAL_ACCUM;
    end else if (opc[15:8] == OPC_AND_LIT_HI) begin
      d.op = OP_AND_LITERAL_ACCUM;
    end else if (opc[15:8] == OPC_BRANCH_C_HI) begin
      d.op = OP_BRANCH_ON_CARRY;
    end else if (opc[15:10] == OPC_ADD_FILE_HI) begin
      d.op = OP_ADD_ACCUM_TO_FILE;
    end else if (opc[15:10] == OPC_ADDC_FILE_HI) begin
      d.op = OP_ADD_ACCUM_FILE_CARRY;
    end else if (opc[15:10] == OPC_AND_FILE_HI) begin
      d.op = OP_AND_ACCUM_FILE;
    end
    return d;
  endfunction : decode_opcode

  // True for operations that take a file register operand
  function automatic logic is_file_op(input aacb_op_e op);
    return (op == OP_ADD_ACCUM_TO_FILE) || (op == OP_ADD_ACCUM_FILE_CARRY) ||
           (op == OP_AND_ACCUM_FILE);
  endfunction : is_file_op

  // Merge write data into an old word under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_w,
                                           input logic [31:0] new_w,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return m;
  endfunction : be_merge

endpackage : aacb_pkg

/* hdl/aacb_alu.sv */
`timescale 1ns/100ps
module aacb_alu (
  input  wire aacb_pkg::aacb_op_e     op,
  input  wire logic [7:0]             accum,
  input  wire logic [7:0]             operand,
  input  wire aacb_pkg::aacb_status_s status_in,
  output logic [7:0]                  result,
  output aacb_pkg::aacb_status_s      status_out
);
  import aacb_pkg::*;

  logic [8:0] sum9;
  logic [4:0] low5;
  logic       cin;

  // Carry in only for the carry-chained add
  assign cin  = (op == OP_ADD_ACCUM_FILE_CARRY) ? status_in.carry : 1'b0;
  assign sum9 = {1'b0, accum} + {1'b0, operand} + {8'h00, cin};
  assign low5 = {1'b0, accum[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};

  // Result and flags per operation
  always_comb begin
    result     = 8'h00;
    status_out = status_in;
    case (op)
      OP_ADD_LITERAL_ACCUM, OP_ADD_ACCUM_TO_FILE,
      OP_ADD_ACCUM_FILE_CARRY: begin
        result = sum9[7:0];
        status_out.carry          = sum9[8];
        status_out.low_nibble_out = low5[4];
        status_out.twos_comp_error_bit = (accum[7] == operand[7]) &&
                                         (sum9[7] != accum[7]);
        status_out.negative = sum9[7];
        status_out.zero     = (sum9[7:0] == 8'h00);
      end
      OP_AND_LITERAL_ACCUM, OP_AND_ACCUM_FILE: begin
        result = accum & operand;
        status_out.negative = result[7];
        status_out.zero     = (result == 8'h00);
      end
      default: begin
        result = 8'h00;
      end
    endcase
  end

endmodule : aacb_alu

/* hdl/aacb_phase_seq.sv */
`timescale 1ns/100ps
module aacb_phase_seq (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        start,
  input  wire logic        again,
  output aacb_pkg::aacb_phase_e phase_q
);
  import aacb_pkg::*;

  // Four phases per cycle, optionally one more cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase_q <= PHASE_IDLE;
    end else begin
      case (phase_q)
        PHASE_IDLE:  phase_q <= start ? PHASE_ONE : PHASE_IDLE;
        PHASE_ONE:   phase_q <= PHASE_TWO;
        PHASE_TWO:   phase_q <= PHASE_THREE;
        PHASE_THREE: phase_q <= PHASE_FOUR;
        PHASE_FOUR:  phase_q <= again ? PHASE_ONE : PHASE_IDLE;
        default:     phase_q <= PHASE_IDLE;
      endcase
    end
  end

  sequence s_rest_of_cycle;
    phase_q == PHASE_TWO ##1 phase_q == PHASE_THREE ##1
    phase_q == PHASE_FOUR;
  endsequence

  property p_four_phases;
    @(posedge clk) disable iff (reset)
    phase_q == PHASE_ONE |=> s_rest_of_cycle;
  endproperty
  a_four_phases: assert property (p_four_phases)
    else $error("phase order broken");

endmodule : aacb_phase_seq

/* verif/aacb_exec_bench.sv */
`timescale 1ns/100ps
module aacb_exec_bench;
  import aacb_pkg::*;

  logic        clk;
  logic        reset;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  aacb_phase_e exec_phase;
  int          errors;
  int          n_checks;

  aacb_exec uut (
    .clk             (clk),
    .reset           (reset),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .exec_phase      (exec_phase)
  );

  // Free running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic summarize();
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // One bus cycle, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic we, input logic [4:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= we;
    avs_read      <= ~we;
    forever begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic chk_reg(input string nm, input logic [4:0] a,
                         input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, a, 32'h0000_0000, rd);
    check(nm, exp, rd);
  endtask : chk_reg

  task automatic setmem(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MEM_ADDR, {20'h00000, a});
    wr(OFS_MEM_DATA, {24'h000000, d});
  endtask : setmem

  task automatic chk_mem(input logic [11:0] a, input logic [7:0] d);
    wr(OFS_MEM_ADDR, {20'h00000, a});
    chk_reg("mem", OFS_MEM_DATA, {24'h000000, d});
  endtask : chk_mem

  // Start one instruction, then follow its phases until idle
  task automatic run(input logic [15:0] opc, input int ncyc);
    aacb_phase_e ph_seq[4];
    int          n;
    ph_seq = '{PHASE_ONE, PHASE_TWO, PHASE_THREE, PHASE_FOUR};
    n = 0;
    wr(OFS_INSTR, {16'h0000, opc});
    repeat (20) begin
      #1;
      if (exec_phase === PHASE_IDLE) break;
      check("phase", 32'(ph_seq[n % 4]), 32'(exec_phase));
      n++;
      @(posedge clk);
    end
    check("cycles", 32'(ncyc), 32'(n));
  endtask : run

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    summarize();
  end

  // Branch cases: status, start pc, offset, target, busy cycles
  logic [4:0]  br_st  [4] = '{5'h1e, 5'h01, 5'h01, 5'h1f};
  logic [20:0] br_pc  [4] = '{21'h100, 21'h100, 21'h1000, 21'h1000};
  logic [7:0]  br_n   [4] = '{8'h05, 8'h05, 8'h80, 8'h7f};
  logic [20:0] br_exp [4] = '{21'h102, 21'h10c, 21'hf02, 21'h1100};
  int          br_cyc [4] = '{4, 8, 8, 8};

  initial begin
    errors         = 0;
    n_checks       = 0;
    reset          = 1'b1;
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    // Reset values and an unmapped offset
    chk_reg("accum", OFS_ACCUM, 32'h0);
    chk_reg("status", OFS_STATUS, 32'h0);
    chk_reg("pc", OFS_PC, 32'h0);
    chk_reg("unmapped", 5'h02, 32'h0);
    // Literal adds with flag corners
    wr(OFS_ACCUM, 32'h10);
    run(16'h0f15, 4);
    chk_reg("accum", OFS_ACCUM, 32'h25);
    chk_reg("status", OFS_STATUS, 32'h00);
    wr(OFS_ACCUM, 32'h7f);
    run(16'h0f01, 4);
    chk_reg("status", OFS_STATUS, 32'h1a);
    wr(OFS_ACCUM, 32'hff);
    run(16'h0f01, 4);
    chk_reg("accum", OFS_ACCUM, 32'h00);
    chk_reg("status", OFS_STATUS, 32'h07);
    // File add to accumulator, then back to the file
    setmem(12'h020, 8'hc2);
    wr(OFS_ACCUM, 32'h17);
    run(16'h2420, 4);
    chk_reg("accum", OFS_ACCUM, 32'hd9);
    chk_reg("status", OFS_STATUS, 32'h10);
    run(16'h2620, 4);
    chk_mem(12'h020, 8'h9b);
    chk_reg("accum", OFS_ACCUM, 32'hd9);
    chk_reg("status", OFS_STATUS, 32'h11);
    // Carry add through the bank select register
    setmem(12'h340, 8'h02);
    setmem(12'h040, 8'h33);
    wr(OFS_BANK, 32'h3);
    wr(OFS_STATUS, 32'h01);
    wr(OFS_ACCUM, 32'h4d);
    run(16'h2140, 4);
    chk_reg("accum", OFS_ACCUM, 32'h50);
    chk_reg("status", OFS_STATUS, 32'h02);
    // Carry add into the upper access bank half
    setmem(12'hf90, 8'h10);
    wr(OFS_STATUS, 32'h00);
    wr(OFS_ACCUM, 32'h70);
    run(16'h2290, 4);
    chk_mem(12'hf90, 8'h80);
    chk_reg("status", OFS_STATUS, 32'h18);
    // Literal AND keeps carry, digit carry and overflow
    wr(OFS_STATUS, 32'h0b);
    wr(OFS_ACCUM, 32'ha3);
    run(16'h0b5f, 4);
    chk_reg("accum", OFS_ACCUM, 32'h03);
    chk_reg("status", OFS_STATUS, 32'h0b);
    run(16'h0b00, 4);
    chk_reg("status", OFS_STATUS, 32'h0f);
    // File AND to the file and then to the accumulator
    wr(OFS_STATUS, 32'h01);
    wr(OFS_ACCUM, 32'h97);
    setmem(12'h020, 8'hc2);
    run(16'h1620, 4);
    chk_mem(12'h020, 8'h82);
    chk_reg("accum", OFS_ACCUM, 32'h97);
    chk_reg("status", OFS_STATUS, 32'h11);
    run(16'h1420, 4);
    chk_reg("accum", OFS_ACCUM, 32'h82);
    // Branch on carry: not taken, taken, offset limits
    for (int i = 0; i < 4; i++) begin
      wr(OFS_STATUS, {27'h0, br_st[i]});
      wr(OFS_PC, {11'h000, br_pc[i]});
      run({8'he2, br_n[i]}, br_cyc[i]);
      chk_reg("pc", OFS_PC, {11'h000, br_exp[i]});
      chk_reg("status", OFS_STATUS, {27'h0, br_st[i]});
    end
    // Unknown opcode only steps the program counter and sets a flag
    run(16'h0000, 4);
    chk_reg("pc", OFS_PC, 32'h1102);
    chk_reg("exec_stat", OFS_EXEC_STAT, 32'h41);
    summarize();
  end

endmodule : aacb_exec_bench
